// >>> tb/test_xy_trigger_record_control.sv
`timescale 1ns/1ns
`default_nettype none
module test_xy_trigger_record_control;
	logic             sys_clk = 1'b0;
	logic             sys_rst;
	logic [7:0]       regAddr;
	logic [31:0]      regWrData;
	logic             regWr;
	logic             regRd;
	logic [31:0]      regRdData;
	logic             startKey, stopKey, manualTriggerKey, xyFunctionSelect;
	logic             extTrigIn;
	logic [31:0]      nowSec;
	logic [2:0][7:0]  chSample;
	logic [2:0][3:0]  logicIn;
	logic [2:0]       chIsLogic;
	logic [7:0]       xData;
	logic [1:0][7:0]  yData;
	logic [1:0]       yDraw;
	logic             plotStrobe, lineMode, clearDisplay, recording, trigPulse;
	logic [31:0]      rdQ[$];        // Expected read data, oldest first.
	logic             trigQ[$];      // Expected recording level at each trigger.
	logic             rdPend = 1'b0; // A read was taken on the last edge.
	logic             strict = 1'b1; // Unannounced triggers count as faults.
	int               nClr = 0;      // Display clear pulses seen.
	int               mismatches = 0;
	int               n_checks = 0;
	logic [31:0]      rnd = 32'h80f5;
	logic [7:0]       hi, lo;
	int               i, k, s;
	xytrc_top #(.SW(8)) dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .regAddr(regAddr),
		.regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
		.xyFunctionSelect(xyFunctionSelect), .startKey(startKey), .stopKey(stopKey),
		.manualTriggerKey(manualTriggerKey), .extTrigIn(extTrigIn), .nowSec(nowSec),
		.chSample(chSample), .logicIn(logicIn), .chIsLogic(chIsLogic), .xData(xData),
		.yData(yData), .yDraw(yDraw), .plotStrobe(plotStrobe), .lineMode(lineMode),
		.clearDisplay(clearDisplay), .recording(recording), .trigPulse(trigPulse));
	xytrc_panel panel (.clk(sys_clk), .startKey(startKey), .stopKey(stopKey),
		.manualTriggerKey(manualTriggerKey), .xyFunctionSelect(xyFunctionSelect));
	// A 40 ns period gives the 25 MHz system clock.
	always #20 sys_clk = ~sys_clk;
	// Xorshift keeps sample values varied yet repeatable from run to run.
	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction
	task automatic cmp(input logic [31:0] g, input logic [31:0] e, input string m);
		n_checks++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// One-cycle register write; the strobe drops on the next edge.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge sys_clk);
		regWr <= 1'b0;
	endtask
	// One-cycle register read; the monitor checks the data a cycle later.
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		rdQ.push_back(e);
		@(posedge sys_clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge sys_clk);
		regRd <= 1'b0;
	endtask
	// Bounded wait until every announced trigger has been seen.
	task automatic waitTrig(input int lim);
		for (i = 0; i < lim && trigQ.size() != 0; i++) @(posedge sys_clk);
		if (trigQ.size() != 0) begin
			mismatches++;
			$display("[FAIL] %0t trigger missing", $time);
			results();
		end
		repeat (2) @(posedge sys_clk);
	endtask
	// Bounded wait for the next plot strobe; a missing strobe ends the run.
	task automatic waitPlot;
		for (i = 0; i < 3200 && plotStrobe !== 1'b1; i++) @(posedge sys_clk);
		if (plotStrobe !== 1'b1) begin
			mismatches++;
			$display("[FAIL] %0t plot strobe missing", $time);
			results();
		end
	endtask
	// Watches outputs; each result takes the oldest note off its queue.
	always @(posedge sys_clk) begin
		rdPend <= regRd;
		if (rdPend && rdQ.size() > 0) cmp(regRdData, rdQ.pop_front(), "read");
		if (clearDisplay === 1'b1) nClr <= nClr + 1;
		if (trigPulse === 1'b1) begin
			if (trigQ.size() > 0) cmp({31'h0, recording}, {31'h0, trigQ.pop_front()}, "rec");
			else if (strict) cmp(32'h1, 32'h0, "unexpected trigger");
		end
	end
	initial begin
		sys_rst = 1'b1;
		regAddr = '0;
		regWrData = '0;
		regWr = 1'b0;
		regRd = 1'b0;
		extTrigIn = 1'b0;
		nowSec = '0;
		chSample = '0;
		logicIn = '0;
		chIsLogic = 3'b100;
		repeat (3) @(posedge sys_clk);
		sys_rst <= 1'b0;
		rd(xytrc_pkg::ADDR_CTRL, xytrc_pkg::RST_CTRL);
		rd(xytrc_pkg::ADDR_LEVEL, xytrc_pkg::RST_LEVEL);
		rd(8'h1C, 32'h0000_0000);
		wr(xytrc_pkg::ADDR_LEVEL, 32'h0032_327F);
		rd(xytrc_pkg::ADDR_LEVEL, 32'h0032_3264);
		wr(xytrc_pkg::ADDR_LEVEL, xytrc_pkg::RST_LEVEL);
		// No source on: the start key itself triggers; first with clear and line.
		for (k = 0; k < 2; k++) begin
			wr(xytrc_pkg::ADDR_CTRL, k ? 32'h0000_0000 : 32'h0000_0300);
			// The option lands one edge after the write and shows one edge later.
			repeat (2) @(posedge sys_clk);
			cmp({31'h0, lineMode}, k ? 32'h0 : 32'h1, "line mode");
			trigQ.push_back(1'b1);
			panel.press(0);
			waitTrig(10);
			cmp(nClr, 1, "display clear");
			panel.press(1);
		end
		// Keys are refused while the XY function is deselected.
		panel.sel(1'b0);
		panel.press(0);
		repeat (2) @(posedge sys_clk);
		cmp({31'h0, recording}, 32'h0, "deselected");
		panel.sel(1'b1);
		// Manual and external both enabled: either one fires the trigger.
		wr(xytrc_pkg::ADDR_CTRL, 32'h0000_0018);
		for (k = 0; k < 2; k++) begin
			panel.press(0);
			repeat (2) @(posedge sys_clk);
			cmp({31'h0, recording}, 32'h0, "armed");
			trigQ.push_back(1'b1);
			if (k == 0) panel.press(2);
			else extTrigIn <= 1'b1;
			waitTrig(10);
			extTrigIn <= 1'b0;
			panel.press(1);
		end
		// Stop timing: the start key records, the trigger ends it.
		wr(xytrc_pkg::ADDR_CTRL, 32'h0000_0048);
		panel.press(0);
		repeat (2) @(posedge sys_clk);
		cmp({31'h0, recording}, 32'h1, "stop mode");
		trigQ.push_back(1'b0);
		extTrigIn <= 1'b1;
		waitTrig(10);
		extTrigIn <= 1'b0;
		// Start-and-stop timing: recording follows the external level.
		wr(xytrc_pkg::ADDR_CTRL, 32'h0000_0088);
		strict = 1'b0;
		panel.press(0);
		for (k = 0; k < 2; k++) begin
			extTrigIn <= (k == 0);
			repeat (3) @(posedge sys_clk);
			cmp({31'h0, recording}, (k == 0), "gate");
		end
		panel.press(1);
		strict = 1'b1;
		// Timer in start mode fires once at the start time, interval aside.
		wr(xytrc_pkg::ADDR_TSTART, 32'h0000_0005);
		wr(xytrc_pkg::ADDR_TSTOP, 32'h0000_0009);
		wr(xytrc_pkg::ADDR_TINTV, 32'h0000_0001);
		wr(xytrc_pkg::ADDR_CTRL, 32'h0000_0020);
		panel.press(0);
		trigQ.push_back(1'b1);
		nowSec <= 32'h0000_0005;
		waitTrig(10);
		nowSec <= 32'h0000_0006;
		repeat (4) @(posedge sys_clk);
		panel.press(1);
		// Channel one threshold crossing, rising then falling slope.
		for (s = 0; s < 2; s++) begin
			rnd = xs(rnd);
			hi = 8'h80 | rnd[7:0];
			lo = 8'h7F & rnd[15:8];
			wr(xytrc_pkg::ADDR_CTRL, 32'h0000_0001 | ((1 - s) << 10));
			chSample[0] <= s ? hi : lo;
			chSample[1] <= rnd[23:16];
			repeat (6300) @(posedge sys_clk);
			panel.press(0);
			trigQ.push_back(1'b1);
			chSample[0] <= s ? lo : hi;
			waitTrig(3200);
			waitPlot();
			cmp({24'h0, xData}, {24'h0, s ? lo : hi}, "x data");
			cmp({24'h0, yData[0]}, {24'h0, rnd[23:16]}, "y data");
			cmp({30'h0, yDraw}, 32'h1, "drawable");
			panel.press(1);
		end
		// Timer in start-and-stop timing repeats each second up to the stop time.
		wr(xytrc_pkg::ADDR_CTRL, 32'h0000_00A0);
		// The schedule needs one cycle with the timer enabled before it fires.
		repeat (2) @(posedge sys_clk);
		for (k = 5; k < 10; k++) begin
			trigQ.push_back(1'b0);
			nowSec <= k;
			waitTrig(10);
		end
		// Past the stop time nothing more may fire; the monitor flags any pulse.
		nowSec <= 32'h0000_000A;
		repeat (4) @(posedge sys_clk);
		// Logic channel two: AND needs every cared bit, OR only one of them.
		wr(xytrc_pkg::ADDR_LOGIC, 32'h0000_1300);
		for (k = 0; k < 2; k++) begin
			rnd = xs(rnd);
			logicIn[1] <= {rnd[3:2], 2'b10};
			chIsLogic <= {rnd[4], 2'b10};
			chSample[2] <= rnd[15:8];
			wr(xytrc_pkg::ADDR_CTRL, k ? 32'h0000_0002 : 32'h0000_2002);
			// Let one sampling tick record the mismatching pattern first.
			repeat (3200) @(posedge sys_clk);
			panel.press(0);
			trigQ.push_back(1'b1);
			logicIn[1] <= {rnd[3:2], k ? 2'b00 : 2'b01};
			waitTrig(3200);
			waitPlot();
			cmp({24'h0, yData[1]}, {24'h0, rnd[15:8]}, "y data");
			cmp({30'h0, yDraw}, {30'h0, ~rnd[4], 1'b0}, "logic drawing");
			panel.press(1);
		end
		results();
	end
endmodule
`default_nettype wire

// >>> tb/xytrc_panel.sv
`timescale 1ns/1ns
`default_nettype none
// Operator panel model: keys are single-cycle pulses launched after an edge.
module xytrc_panel (
	input  wire logic clk,
	output logic      startKey,
	output logic      stopKey,
	output logic      manualTriggerKey,
	output logic      xyFunctionSelect
);
	// Keys rest released and the XY function is selected from time zero.
	initial begin
		startKey = 1'b0;
		stopKey = 1'b0;
		manualTriggerKey = 1'b0;
		xyFunctionSelect = 1'b1;
	end
	// Press one key for one cycle: 0 start, 1 stop, 2 manual trigger.
	task automatic press(input int k);
		@(posedge clk);
		startKey <= (k == 0);
		stopKey <= (k == 1);
		manualTriggerKey <= (k == 2);
		@(posedge clk);
		startKey <= 1'b0;
		stopKey <= 1'b0;
		manualTriggerKey <= 1'b0;
	endtask
	// Switch the XY function on or off, as the operator menu would.
	task automatic sel(input logic on);
		@(posedge clk);
		xyFunctionSelect <= on;
	endtask
endmodule
`default_nettype wire

// >>> verilog/xytrc_pkg.sv
`default_nettype none
package xytrc_pkg;
	// Register word addresses on the local port.
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_LEVEL  = 8'h04;
	localparam logic [7:0] ADDR_LOGIC  = 8'h08;
	localparam logic [7:0] ADDR_TSTART = 8'h0C;
	localparam logic [7:0] ADDR_TSTOP  = 8'h10;
	localparam logic [7:0] ADDR_TINTV  = 8'h14;
	localparam logic [7:0] ADDR_STATUS = 8'h18;
	// Field layout of the level and logic pattern words.
	localparam int LVL_W     = 7;
	localparam int LVL_STEP  = 8;
	localparam int PAT_W     = 4;
	localparam int PAT_STEP  = 8;
	localparam int CTRL_W    = 14;
	localparam logic [6:0] LVL_MAX = 7'h64;
	// Reset values.
	localparam logic [31:0] RST_CTRL  = 32'h0000_0000;
	localparam logic [31:0] RST_LEVEL = 32'h0032_3232;
	localparam logic [31:0] RST_LOGIC = 32'h0000_0000;
	localparam logic [31:0] RST_TIME  = 32'h0000_0000;
	// Trigger sampling period and clock period, in nanoseconds.
	localparam int SAMPLE_NS = 125000;
	localparam int CLK_NS    = 40;
	localparam int TICK_CYC  = SAMPLE_NS / CLK_NS;
	// Record timing modes.
	typedef enum logic [1:0] {MODE_START, MODE_STOP, MODE_STARTSTOP} xytrc_mode_t;
	// Control word, most significant field first.
	typedef struct packed {
		logic        logicAnd;
		logic [2:0]  slopePos;
		logic        lineMode;
		logic        dispClear;
		xytrc_mode_t mode;
		logic        timerEn;
		logic        manualEn;
		logic        extEn;
		logic [2:0]  chEn;
	} xytrc_ctrl_t;
endpackage
`default_nettype wire

// >>> verilog/xytrc_top.sv
// How it works
// - Any enabled source fires the trigger.
// - No source enabled: start key triggers.
// - Start mode records from trigger onward.
// - Stop mode: start key records, trigger ends.
// - Start-and-stop mode records while condition holds.
// - Timer fires each interval, start to stop.
// - Zero interval fires timer once at start.
// - Start or stop mode ignores timer interval.
// - Threshold is percent of full scale.
// - Slope picks upward or downward crossing.
// - Display clear on start key, else overlay.
// - Line mode joins points, dot plots only.
// - Manual key fires trigger when enabled.
// - External input fires trigger when enabled.
// - Channel one is X, others are Y.
// - Logic channels two and three trigger only, never drawn.
// - Trigger sampling at fixed 125 us period.
// - Logic patterns combine by AND or OR.
//
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module xytrc_top #(
	parameter int SW = 8
) (
	input  wire logic                sys_clk,
	input  wire logic                sys_rst,
	input  wire logic [7:0]          regAddr,
	input  wire logic [31:0]         regWrData,
	input  wire logic                regWr,
	input  wire logic                regRd,
	output logic      [31:0]         regRdData,
	input  wire logic                xyFunctionSelect,
	input  wire logic                startKey,
	input  wire logic                stopKey,
	input  wire logic                manualTriggerKey,
	input  wire logic                extTrigIn,
	input  wire logic [31:0]         nowSec,
	input  wire logic [2:0][SW-1:0]  chSample,
	input  wire logic [2:0][3:0]     logicIn,
	input  wire logic [2:0]          chIsLogic,
	output logic      [SW-1:0]       xData,
	output logic      [1:0][SW-1:0]  yData,
	output logic      [1:0]          yDraw,
	output logic                     plotStrobe,
	output logic                     lineMode,
	output logic                     clearDisplay,
	output logic                     recording,
	output logic                     trigPulse
);
	// Sample codes must leave room for the percent products.
	if (SW < 2 || SW > 16) begin : gBadWidth
		$error("xytrc_top: SW must lie between 2 and 16");
	end

	typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_REC} xytrc_state_t;

	localparam logic [SW+6:0] FULL_PCT = (SW+7)'(100);
	localparam logic [SW+6:0] FULL_CODE = (SW+7)'((1 << SW) - 1);

	xytrc_pkg::xytrc_ctrl_t ctrl_r;       // Source enables, mode and drawing options.
	logic [31:0]            level_r;      // Per-channel trigger level in percent.
	logic [31:0]            logic_r;      // Per-channel care mask and pattern.
	logic [31:0]            tStart_r;     // Timer start time in seconds.
	logic [31:0]            tStop_r;      // Timer stop time in seconds.
	logic [31:0]            tIntv_r;      // Timer interval in seconds.
	xytrc_state_t           state_r;      // Record control state.
	xytrc_state_t           state_nxt;    // Next record control state.
	logic [11:0]            divCnt_r;     // Sampling divider.
	logic                   tick;         // One-cycle sampling enable.
	logic [2:0]             chEdge;       // Per-channel trigger pulses.
	logic [2:0]             chHold;       // Per-channel trigger condition levels.
	logic                   extPrev_r;    // External input one cycle ago.
	logic [31:0]            secPrev_r;    // Time value one cycle ago.
	logic [31:0]            nextFire_r;   // Next timer firing time.
	logic                   timerDone_r;  // Timer has run out.
	logic                   timerArm_r;   // Timer enable seen last cycle.
	logic                   timerFire;    // Timer trigger pulse.
	logic [31:0]            intvEff;      // Interval as actually used.
	logic                   anyEnabled;   // At least one source is on.
	logic                   trigFire;     // Combined trigger pulse.
	logic                   gateHold;     // Condition for gated recording.
	logic                   recNxt;       // Next value of the recording flag.

	// Software writes; a level above full scale is clamped so the compare stays meaningful.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			ctrl_r   <= xytrc_pkg::CTRL_W'(xytrc_pkg::RST_CTRL);
			level_r  <= xytrc_pkg::RST_LEVEL;
			logic_r  <= xytrc_pkg::RST_LOGIC;
			tStart_r <= xytrc_pkg::RST_TIME;
			tStop_r  <= xytrc_pkg::RST_TIME;
			tIntv_r  <= xytrc_pkg::RST_TIME;
		end else if (regWr) begin
			case (regAddr)
				xytrc_pkg::ADDR_CTRL: begin
					ctrl_r <= xytrc_pkg::xytrc_ctrl_t'(regWrData[xytrc_pkg::CTRL_W-1:0]);
				end
				xytrc_pkg::ADDR_LEVEL: begin
					for (int i = 0; i < 3; i++) begin
						level_r[i*xytrc_pkg::LVL_STEP +: xytrc_pkg::LVL_STEP] <=
							{1'b0, (regWrData[i*xytrc_pkg::LVL_STEP +: xytrc_pkg::LVL_W] >
							xytrc_pkg::LVL_MAX) ? xytrc_pkg::LVL_MAX :
							regWrData[i*xytrc_pkg::LVL_STEP +: xytrc_pkg::LVL_W]};
					end
				end
				xytrc_pkg::ADDR_LOGIC:  logic_r  <= regWrData;
				xytrc_pkg::ADDR_TSTART: tStart_r <= regWrData;
				xytrc_pkg::ADDR_TSTOP:  tStop_r  <= regWrData;
				xytrc_pkg::ADDR_TINTV:  tIntv_r  <= regWrData;
				default: begin
				end
			endcase
		end
	end

	// Read data stand for exactly one cycle after the strobe; unmapped words read zero.
	always_ff @(posedge sys_clk) begin
		if (sys_rst || !regRd) begin
			regRdData <= 32'h0000_0000;
		end else begin
			case (regAddr)
				xytrc_pkg::ADDR_CTRL:   regRdData <= 32'(ctrl_r);
				xytrc_pkg::ADDR_LEVEL:  regRdData <= level_r;
				xytrc_pkg::ADDR_LOGIC:  regRdData <= logic_r;
				xytrc_pkg::ADDR_TSTART: regRdData <= tStart_r;
				xytrc_pkg::ADDR_TSTOP:  regRdData <= tStop_r;
				xytrc_pkg::ADDR_TINTV:  regRdData <= tIntv_r;
				xytrc_pkg::ADDR_STATUS: regRdData <= {28'h000_0000, timerDone_r, recording,
					2'(state_r)};
				default:                regRdData <= 32'h0000_0000;
			endcase
		end
	end

	// The sampling rate is fixed, whatever the dot or line setting.
	always_ff @(posedge sys_clk) begin
		if (sys_rst || divCnt_r == 12'(xytrc_pkg::TICK_CYC - 1)) begin
			divCnt_r <= 12'h000;
		end else begin
			divCnt_r <= divCnt_r + 12'h001;
		end
	end
	assign tick = (divCnt_r == 12'(xytrc_pkg::TICK_CYC - 1));

	// Each channel is either an analog level detector or a logic pattern matcher.
	for (genvar i = 0; i < 3; i++) begin : gCh
		localparam int PAT_MSB = xytrc_pkg::PAT_W - 1;
		logic [xytrc_pkg::LVL_W-1:0] lvl;
		logic [PAT_MSB:0]            care;
		logic [PAT_MSB:0]            want;
		logic                        curHi;
		logic                        prevHi_r;
		logic                        match;
		logic                        prevMatch_r;
		logic                        aEdge;
		assign lvl  = level_r[i*xytrc_pkg::LVL_STEP +: xytrc_pkg::LVL_W];
		assign care = logic_r[i*xytrc_pkg::PAT_STEP +: xytrc_pkg::PAT_W];
		assign want = logic_r[i*xytrc_pkg::PAT_STEP+xytrc_pkg::PAT_W +: xytrc_pkg::PAT_W];
		// Cross-multiplied so no divider is needed for the percent scale.
		assign curHi = ({7'h00, chSample[i]} * FULL_PCT) >=
			({{SW{1'b0}}, lvl} * FULL_CODE);
		assign match = ctrl_r.logicAnd ? &(~(logicIn[i] ^ want) | ~care) :
			|(~(logicIn[i] ^ want) & care);
		assign aEdge = ctrl_r.slopePos[i] ? (curHi && !prevHi_r) : (!curHi && prevHi_r);
		// Previous samples are taken only on the sampling tick.
		always_ff @(posedge sys_clk) begin
			if (sys_rst) begin
				prevHi_r    <= 1'b0;
				prevMatch_r <= 1'b0;
			end else if (tick) begin
				prevHi_r    <= curHi;
				prevMatch_r <= match;
			end
		end
		assign chEdge[i] = ctrl_r.chEn[i] && tick &&
			(chIsLogic[i] ? (match && !prevMatch_r) : aEdge);
		assign chHold[i] = ctrl_r.chEn[i] &&
			(chIsLogic[i] ? match : (ctrl_r.slopePos[i] ? curHi : !curHi));
	end

	// Outside start-and-stop mode the timer acts once, as if the interval were zero.
	assign intvEff = (ctrl_r.mode == xytrc_pkg::MODE_STARTSTOP) ? tIntv_r : 32'h0000_0000;
	assign timerFire = ctrl_r.timerEn && timerArm_r && !timerDone_r && (nowSec != secPrev_r) &&
		(nowSec == nextFire_r) && (nowSec <= tStop_r);

	// Timer schedule; enabling it restarts the schedule at the start time.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			secPrev_r   <= 32'h0000_0000;
			nextFire_r  <= 32'h0000_0000;
			timerDone_r <= 1'b0;
			timerArm_r  <= 1'b0;
		end else begin
			secPrev_r  <= nowSec;
			timerArm_r <= ctrl_r.timerEn;
			if (!timerArm_r) begin
				nextFire_r  <= tStart_r;
				timerDone_r <= 1'b0;
			end else if (timerFire) begin
				nextFire_r  <= nextFire_r + intvEff;
				timerDone_r <= (intvEff == 32'h0000_0000);
			end else if (nowSec > tStop_r) begin
				timerDone_r <= 1'b1;
			end
		end
	end

	assign anyEnabled = (|ctrl_r.chEn) || ctrl_r.extEn || ctrl_r.manualEn || ctrl_r.timerEn;
	assign trigFire = anyEnabled ? ((|chEdge) || (ctrl_r.extEn && extTrigIn && !extPrev_r) ||
		(ctrl_r.manualEn && manualTriggerKey) || timerFire) : startKey;
	assign gateHold = anyEnabled ? ((|chHold) || (ctrl_r.extEn && extTrigIn)) : 1'b1;

	// Record control; a stop key or leaving the XY function always ends recording.
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (startKey) begin
					if (ctrl_r.mode == xytrc_pkg::MODE_STOP) begin
						state_nxt = ST_REC;
					end else if (ctrl_r.mode == xytrc_pkg::MODE_STARTSTOP || !trigFire) begin
						state_nxt = ST_ARMED;
					end else begin
						state_nxt = ST_REC;
					end
				end
			end
			ST_ARMED: begin
				if (ctrl_r.mode != xytrc_pkg::MODE_STARTSTOP && trigFire) begin
					state_nxt = ST_REC;
				end
			end
			ST_REC: begin
				if (ctrl_r.mode == xytrc_pkg::MODE_STOP && trigFire) begin
					state_nxt = ST_IDLE;
				end
			end
			default: state_nxt = ST_IDLE;
		endcase
		if (stopKey || !xyFunctionSelect) begin
			state_nxt = ST_IDLE;
		end
	end
	assign recNxt = (state_nxt == ST_REC) || (state_nxt == ST_ARMED &&
		ctrl_r.mode == xytrc_pkg::MODE_STARTSTOP && gateHold);

	// State and status flags.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			state_r   <= ST_IDLE;
			recording <= 1'b0;
			extPrev_r <= 1'b0;
			trigPulse <= 1'b0;
		end else begin
			state_r   <= state_nxt;
			recording <= recNxt;
			extPrev_r <= extTrigIn;
			trigPulse <= trigFire && xyFunctionSelect;
		end
	end

	// Plot outputs; values are held between strobes so the drawer can interpolate.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			xData        <= '0;
			yData        <= '0;
			yDraw        <= 2'b00;
			plotStrobe   <= 1'b0;
			lineMode     <= 1'b0;
			clearDisplay <= 1'b0;
		end else begin
			plotStrobe   <= tick && recording;
			lineMode     <= ctrl_r.lineMode;
			clearDisplay <= startKey && ctrl_r.dispClear && state_r == ST_IDLE &&
				xyFunctionSelect;
			yDraw        <= ~chIsLogic[2:1];
			if (tick && recording) begin
				xData <= chSample[0];
				yData <= chSample[2:1];
			end
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	trig_or_a: assert property ((|chEdge) |-> trigFire)
		else $error("Enabled channel edge gave no trigger.");
	start_trig_a: assert property ((!anyEnabled && startKey) |-> trigFire)
		else $error("Start key did not trigger with all sources off.");
	start_wait_a: assert property ((state_r == ST_ARMED && ctrl_r.mode == xytrc_pkg::MODE_START)
		|-> !recording)
		else $error("Recording before trigger in start mode.");
	stop_end_a: assert property ((state_r == ST_REC && ctrl_r.mode == xytrc_pkg::MODE_STOP &&
		trigFire) |=> (state_r == ST_IDLE && !recording))
		else $error("Trigger did not end recording in stop mode.");
	gate_rec_a: assert property ((state_r == ST_ARMED && ctrl_r.mode == xytrc_pkg::MODE_STARTSTOP
		&& !stopKey && xyFunctionSelect) |=> (recording == $past(gateHold)))
		else $error("Gated recording does not follow the condition.");
	tick_gap_a: assert property (tick |=> (!tick)[*8])
		else $error("Sampling ticks too close.");
	timer_once_a: assert property ((timerFire && intvEff == 32'h0000_0000) |=> timerDone_r)
		else $error("Zero interval timer not stopped.");
	clear_a: assert property ((startKey && ctrl_r.dispClear && state_r == ST_IDLE &&
		xyFunctionSelect) |=> clearDisplay)
		else $error("Display clear missing on start key.");
	x_axis_a: assert property ((tick && recording) |=> (xData == $past(chSample[0])))
		else $error("X axis not taken from channel one.");
	logic_draw_a: assert property (yDraw[0] |-> !$past(chIsLogic[1]))
		else $error("Logic channel marked for drawing.");

	rec_start_c: cover property (state_r == ST_ARMED ##1 state_r == ST_REC);
	stop_mode_c: cover property (ctrl_r.mode == xytrc_pkg::MODE_STOP && state_r == ST_REC
		##1 state_r == ST_IDLE);
	gate_c: cover property (ctrl_r.mode == xytrc_pkg::MODE_STARTSTOP && $rose(recording));
	timer_c: cover property (timerFire);
endmodule
`default_nettype wire
